// >>> logic/mdma_pkg.sv
// Constants, field layouts and types for the multichannel DMA arbiter
package mdma_pkg;
	localparam int NCH  = 24;
	localparam int NTD  = 128;
	localparam int NLVL = 8;

	// Register map, 12-bit byte addresses
	localparam logic [11:0] A_GLOBAL = 12'h100;
	localparam int          A_POOL   = 11;

	// Channel control word
	localparam int C_EN    = 0;
	localparam int C_PRIO  = 1;
	localparam int C_NORR  = 4;
	localparam int C_FIRST = 5;
	localparam int C_STALL = 12;
	localparam int C_HWEN  = 13;
	localparam int C_HWSEL = 14;
	localparam int C_CHEN  = 19;
	localparam int C_CHSRC = 20;
	localparam logic [31:0] CTRL_MASK = 32'h01ff_ffff;

	// Command bits and global control
	localparam int K_START  = 0;
	localparam int K_CANCEL = 1;
	localparam int G_FAIR   = 0;

	// Transaction descriptor words and config word
	localparam logic [1:0] W_SRC = 2'h0;
	localparam logic [1:0] W_DST = 2'h1;
	localparam logic [1:0] W_CFG = 2'h2;
	localparam int D_LEN   = 0;
	localparam int D_INF   = 16;
	localparam int D_NEXT  = 17;
	localparam int D_CHAIN = 24;
	localparam int D_SINC  = 25;
	localparam int D_DINC  = 26;
	localparam int D_IRQA  = 27;
	localparam int D_IRQB  = 28;

	// Destination addresses whose top bits match this are written into the descriptor pool
	localparam logic [19:0] DESC_WIN   = 20'hfffff;
	localparam logic [4:0]  STARVE_CYC = 5'h10;

	typedef enum logic [1:0] {E_IDLE, E_RD, E_WW, E_WR} mdma_eng_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} mdma_wbreq_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [7:0]  dat;
	} mdma_mreq_t;

	typedef struct packed {
		mdma_eng_t                st;
		logic [4:0]               ch;
		logic [7:0]               data;
		mdma_mreq_t               m;
		logic [5:0]               fcnt;
		logic [4:0]               starve;
		logic                     fair;
		logic [NCH-1:0]           act;
		logic [NCH-1:0]           done;
		logic [NCH-1:0]           irqa;
		logic [NCH-1:0]           irqb;
		logic [NCH-1:0]           s1;
		logic [NCH-1:0]           s2;
		logic [NCH-1:0]           s3;
		logic [NCH-1:0][6:0]      td;
		logic [NCH-1:0][15:0]     off;
		logic [NCH-1:0][31:0]     ctrl;
		logic [NLVL-1:0][4:0]     rr;
		logic                     ack;
		logic [31:0]              rdat;
	} mdma_state_t;
endpackage

// >>> logic/mdma_top.sv
// Multichannel DMA engine with descriptor pool, arbiter and Wishbone slave
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module mdma_top (
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_in,
	input  wire mdma_pkg::mdma_wbreq_t  wb_in,
	output logic                        wb_ack_out,
	output logic [31:0]                 wb_dat_out,
	input  wire logic [mdma_pkg::NCH-1:0] trig_in,
	input  wire logic                   cpu_req_in,
	output mdma_pkg::mdma_mreq_t        mst_out,
	input  wire logic                   mst_ack_in,
	input  wire logic [7:0]             mst_dat_in,
	output logic [mdma_pkg::NCH-1:0]    irq_a_out,
	output logic [mdma_pkg::NCH-1:0]    irq_b_out
);
	import mdma_pkg::*;

	mdma_state_t          q;
	mdma_state_t          n;
	logic [31:0]          pool [0:NTD*4-1];
	logic [NCH-1:0]       req;
	logic [NCH-1:0]       norr;
	logic [NLVL-1:0][NCH-1:0] lreq;
	logic [NLVL-1:0]      lany;
	logic [2:0]           flvl;
	logic [2:0]           glvl;
	logic [5:0]           pk;
	logic                 gv;
	logic [4:0]           gch;
	logic [31:0]          g_src;
	logic [31:0]          g_cfg;
	logic [31:0]          c_cfg;
	logic [31:0]          dadr;
	logic                 acc;
	logic                 pool_wr;
	logic                 pw;
	logic                 fin;
	logic [NCH-1:0]       kstart;
	logic [NCH-1:0]       kcan;
	logic [31:0]          edge_v;
	logic [31:0]          done_v;
	logic [4:0]           wc;
	logic                 st;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction

	// Lowest index at or above the rotating pointer wins, else lowest overall; opted-out channels beat the pointer
	function automatic logic [5:0] pick(input logic [NCH-1:0] rq, input logic [NCH-1:0] nr,
		input logic [4:0] ptr);
		logic [5:0] r;
		r = 6'h0;
		for (int i = NCH-1; i >= 0; i--)
			if (rq[i])
				r = {1'b1, 5'(i)};
		for (int i = NCH-1; i >= 0; i--)
			if (rq[i] && i >= int'(ptr))
				r = {1'b1, 5'(i)};
		for (int i = NCH-1; i >= 0; i--)
			if (rq[i] && nr[i])
				r = {1'b1, 5'(i)};
		return r;
	endfunction

	//--------------------------------------------------------------
	// Arbiter
	//--------------------------------------------------------------
	always_comb
	begin
		req = '0;
		norr = '0;
		lreq = '0;
		for (int c = 0; c < NCH; c++)
		begin
			req[c] = q.act[c] & q.ctrl[c][C_EN] & ~q.ctrl[c][C_STALL];
			norr[c] = q.ctrl[c][C_NORR];
			lreq[q.ctrl[c][C_PRIO +: 3]][c] = req[c];
		end
		for (int l = 0; l < NLVL; l++)
			lany[l] = |lreq[l];
		// Slot counter: lowest set bit b forces level b+2, halving each step
		flvl = 3'h7;
		for (int b = 5; b >= 0; b--)
			if (q.fcnt[b])
				flvl = 3'(b + 2);
		glvl = 3'h0;
		for (int l = NLVL-1; l >= 0; l--)
			if (lany[l])
				glvl = 3'(l);
		if (q.fair && !lany[0] && !lany[1] && q.fcnt != 6'h0 && lany[flvl])
			glvl = flvl;
		pk = pick(lreq[glvl], norr, q.rr[glvl]);
		gv = pk[5];
		gch = pk[4:0];
	end

	assign g_src = pool[{q.td[gch], W_SRC}];
	assign g_cfg = pool[{q.td[gch], W_CFG}];
	assign c_cfg = pool[{q.td[q.ch], W_CFG}];
	assign dadr = pool[{q.td[q.ch], W_DST}] + (c_cfg[D_DINC] ? {16'h0, q.off[q.ch]} : 32'h0);
	assign acc = wb_in.cyc & wb_in.stb & ~q.ack;
	assign pool_wr = acc & wb_in.we & wb_in.adr[A_POOL];
	assign edge_v = {8'h0, q.s2 & ~q.s3};
	assign done_v = {8'h0, q.done};

	//--------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------
	always_comb
	begin
		n = q;
		n.done = '0;
		n.irqa = '0;
		n.irqb = '0;
		n.s1 = trig_in;
		n.s2 = q.s1;
		n.s3 = q.s2;
		fin = 1'b0;
		pw = 1'b0;
		kstart = '0;
		kcan = '0;
		wc = wb_in.adr[7:3];
		st = 1'b0;
		case (q.st)
			E_IDLE:
			begin
				// New access only between transactions
				if (gv && (!cpu_req_in || q.starve == STARVE_CYC))
				begin
					n.ch = gch;
					n.m.adr = g_src + (g_cfg[D_SINC] ? {16'h0, q.off[gch]} : 32'h0);
					n.m.cyc = 1'b1;
					n.m.stb = 1'b1;
					n.m.we = 1'b0;
					n.st = E_RD;
					n.starve = 5'h0;
					n.rr[glvl] = (gch == 5'(NCH-1)) ? 5'h0 : gch + 5'h1;
					if (!lany[0] && !lany[1])
						n.fcnt = q.fcnt + 6'h1;
				end
				else if (gv)
					n.starve = q.starve + 5'h1;
				else
					n.starve = 5'h0;
			end
			E_RD:
				if (mst_ack_in)
				begin
					n.data = mst_dat_in;
					n.m.cyc = 1'b0;
					n.m.stb = 1'b0;
					n.st = E_WW;
				end
			E_WW:
				if (dadr[31:12] == DESC_WIN)
				begin
					pw = 1'b1;
					fin = 1'b1;
					n.st = E_IDLE;
				end
				else
				begin
					n.m.cyc = 1'b1;
					n.m.stb = 1'b1;
					n.m.we = 1'b1;
					n.m.adr = dadr;
					n.m.dat = q.data;
					n.st = E_WR;
				end
			E_WR:
				if (mst_ack_in)
				begin
					n.m.cyc = 1'b0;
					n.m.stb = 1'b0;
					n.m.we = 1'b0;
					fin = 1'b1;
					n.st = E_IDLE;
				end
			default:
				n.st = E_IDLE;
		endcase

		// Byte done: advance, or close the descriptor and follow its chain
		if (fin)
		begin
			if (!c_cfg[D_INF] && q.off[q.ch] == c_cfg[D_LEN +: 16])
			begin
				n.done[q.ch] = 1'b1;
				n.irqa[q.ch] = c_cfg[D_IRQA];
				n.irqb[q.ch] = c_cfg[D_IRQB];
				n.off[q.ch] = 16'h0;
				if (c_cfg[D_CHAIN])
					n.td[q.ch] = c_cfg[D_NEXT +: 7];
				else
					n.act[q.ch] = 1'b0;
			end
			else
				n.off[q.ch] = q.off[q.ch] + 16'h1;
		end

		// Register slave
		n.ack = acc;
		n.rdat = 32'h0;
		if (acc)
		begin
			if (wb_in.adr[A_POOL])
				n.rdat = pool[wb_in.adr[10:2]];
			else if (wb_in.adr == A_GLOBAL)
			begin
				n.rdat = {31'h0, q.fair};
				if (wb_in.we && wb_in.sel[0])
					n.fair = wb_in.dat[G_FAIR];
			end
			else if (wb_in.adr[11:8] == 4'h0 && wc < 5'(NCH))
			begin
				if (!wb_in.adr[2])
				begin
					n.rdat = q.ctrl[wc];
					if (wb_in.we)
						n.ctrl[wc] = merge(q.ctrl[wc], wb_in.dat, wb_in.sel) & CTRL_MASK;
				end
				else
				begin
					n.rdat = {q.off[wc], 7'h0, q.td[wc], q.ctrl[wc][C_STALL], q.act[wc]};
					if (wb_in.we && wb_in.sel[0])
					begin
						kstart[wc] = wb_in.dat[K_START];
						kcan[wc] = wb_in.dat[K_CANCEL];
					end
				end
			end
		end

		// Channel starts; cancel clears act and off, overriding a start or a byte done
		for (int c = 0; c < NCH; c++)
		begin
			st = kstart[c]
				| (q.ctrl[c][C_HWEN] & edge_v[q.ctrl[c][C_HWSEL +: 5]])
				| (q.ctrl[c][C_CHEN] & done_v[q.ctrl[c][C_CHSRC +: 5]]);
			if (st && !n.act[c] && q.ctrl[c][C_EN])
			begin
				n.act[c] = 1'b1;
				n.td[c] = q.ctrl[c][C_FIRST +: 7];
				n.off[c] = 16'h0;
			end
			if (kcan[c])
			begin
				n.act[c] = 1'b0;
				n.off[c] = 16'h0;
			end
		end
	end

	//--------------------------------------------------------------
	// Registers and descriptor pool
	//--------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			q <= '0;
		else
			q <= n;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (pool_wr)
			pool[wb_in.adr[10:2]] <= merge(pool[wb_in.adr[10:2]], wb_in.dat, wb_in.sel);
		if (pw)
			pool[dadr[10:2]][8*dadr[1:0] +: 8] <= q.data;
	end

	assign wb_ack_out = q.ack;
	assign wb_dat_out = q.rdat;
	assign mst_out = q.m;
	assign irq_a_out = q.irqa;
	assign irq_b_out = q.irqb;

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_rd_ack;
		mst_out.cyc && !mst_out.we && mst_ack_in;
	endsequence

	sequence s_gap_then_wr;
		!mst_out.cyc ##1 (mst_out.we || q.st == E_IDLE);
	endsequence

	sequence s_grant;
		q.st == E_IDLE && n.st == E_RD;
	endsequence

	a_wb_answer: assert property
		((wb_in.cyc && wb_in.stb && !wb_ack_out) |=> wb_ack_out)
		else $error("register access not answered next cycle");
	a_cpu_first: assert property
		((q.st == E_IDLE && !mst_out.cyc && cpu_req_in && q.starve != STARVE_CYC) |=> !mst_out.cyc)
		else $error("dma took bus while cpu requested");
	a_no_starve: assert property
		(q.starve <= STARVE_CYC)
		else $error("starvation counter overran");
	a_lvl01_first: assert property
		((gv && (lany[0] || lany[1])) |-> glvl <= 3'h1)
		else $error("level 0 or 1 passed over");
	a_strict_prio: assert property
		((gv && !q.fair) |-> ((lany & ((8'h1 << glvl) - 8'h1)) == 8'h0))
		else $error("strict priority violated");
	a_fair_slot: assert property
		((gv && q.fair && !lany[0] && !lany[1] && q.fcnt[0] && lany[2]) |-> glvl == 3'h2)
		else $error("fairness slot not given to level 2");
	a_irq_pair: assert property
		((|(irq_a_out | irq_b_out)) |-> (((irq_a_out | irq_b_out) & ~q.done) == '0))
		else $error("interrupt without descriptor completion");
	a_cancel_wins: assert property
		((acc && wb_in.we && wb_in.adr[11:8] == 4'h0 && wb_in.adr[2] && wc < 5'(NCH)
			&& wb_in.sel[0] && wb_in.dat[K_CANCEL]) |=> !q.act[$past(wc)])
		else $error("cancel did not stop channel");
	a_hold_req: assert property
		((mst_out.cyc && !mst_ack_in) |=> (mst_out.cyc && $stable(mst_out.adr)))
		else $error("bus request dropped before ack");
	a_rd_then_wr: assert property
		(s_rd_ack |=> s_gap_then_wr)
		else $error("read not followed by gap and write");
	a_grant_live: assert property
		(s_grant |-> (q.act[gch] && q.ctrl[gch][C_EN] && !q.ctrl[gch][C_STALL]))
		else $error("grant to idle, disabled or stalled channel");
	a_grant_bus: assert property
		(s_grant |=> (mst_out.cyc && !mst_out.we))
		else $error("grant did not open a source read");
	a_no_preempt: assert property
		((q.st != E_IDLE) |=> (q.ch == $past(q.ch)))
		else $error("channel switched inside a transaction");
	a_pool_local: assert property
		((q.st == E_WW && dadr[31:12] == DESC_WIN) |=> (!mst_out.cyc && q.st == E_IDLE))
		else $error("descriptor pool write went to the bus");
	a_irq_single: assert property
		((|irq_a_out) |=> ((irq_a_out & $past(irq_a_out)) == '0))
		else $error("interrupt pulse longer than one cycle");
endmodule

// >>> dv/mdma_bus_model.sv
// Byte-wide memory standing on the shared system bus
`timescale 1ns/1ps
module mdma_bus_model (
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	input  wire mdma_pkg::mdma_mreq_t req_in,
	input  wire logic [3:0]           dly_in,
	output logic                      ack_out,
	output logic [7:0]                dat_out
);
	import mdma_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] rd_q;
	logic [3:0] cnt_q;
	// Outside an ack the line shows the inverse of the last byte
	assign dat_out = ack_out ? rd_q : ~rd_q;
	always @(posedge clk_in)
	begin
		ack_out <= 1'b0;
		if (rst_in)
		begin
			cnt_q <= 4'h0;
			rd_q  <= 8'h00;
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'(i) ^ 8'h5a;
		end
		else if (req_in.cyc && req_in.stb && !ack_out)
		begin
			if (cnt_q >= dly_in)
			begin
				ack_out <= 1'b1;
				cnt_q   <= 4'h0;
				rd_q    <= mem[req_in.adr[7:0]];
				if (req_in.we)
					mem[req_in.adr[7:0]] <= req_in.dat;
			end
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the multichannel DMA arbiter
`timescale 1ns/1ps
module tb;
	import mdma_pkg::*;
	logic           clk = 1'b0;
	logic           rst = 1'b1;
	logic           cpu = 1'b0;
	logic [3:0]     dly = 4'h0;
	logic [NCH-1:0] trig = '0;
	mdma_wbreq_t    wb = '0;
	mdma_mreq_t     mreq;
	logic           ack, mack;
	logic [31:0]    rdat;
	logic [7:0]     mdat;
	logic [NCH-1:0] irqa, irqb;
	int             error_cnt = 0;
	int             comparisons = 0;

	always #20 clk = ~clk;

	mdma_top uut (.core_clk_in(clk), .rst_in(rst), .wb_in(wb), .wb_ack_out(ack),
		.wb_dat_out(rdat), .trig_in(trig), .cpu_req_in(cpu), .mst_out(mreq),
		.mst_ack_in(mack), .mst_dat_in(mdat), .irq_a_out(irqa), .irq_b_out(irqb));
	mdma_bus_model mdl (.clk_in(clk), .rst_in(rst), .req_in(mreq), .dly_in(dly),
		.ack_out(mack), .dat_out(mdat));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			error_cnt++;
		q = rdat;
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, q & m, e);
	endtask

	task automatic td(input int i, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] c);
		wr(12'(12'h800 + i * 16), s);
		wr(12'(12'h804 + i * 16), d);
		wr(12'(12'h808 + i * 16), c);
	endtask

	task automatic irq_wait(input int ch, input logic eb, input string nm);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (irqa[ch] !== 1'b1 && n < 3000);
		chk(nm, {30'h0, irqb[ch], irqa[ch]}, {30'h0, eb, 1'b1});
		@(posedge clk);
	endtask

	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'h5a;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs;
		rd(12'h000, '1, 32'h0, "ctrl0 reset");
		rd(12'h0c0, '1, 32'h0, "past last channel");
		wr(12'h0b8, 32'hffffffff);
		rd(12'h0b8, '1, CTRL_MASK, "ctrl23 fields");
		wr(12'h0b8, 32'h0);
	endtask

	task automatic s_simple;
		int n;
		dly <= 4'h2;
		td(0, 32'h10, 32'h40, 32'h1e00_0003);
		wr(12'h000, 32'h1);
		cpu <= 1'b1;
		wr(12'h004, 32'h1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (mreq.cyc !== 1'b1 && n < 40);
		chk("cpu held off", 32'(n >= 15 && n <= 19), 32'h1);
		@(posedge clk);
		cpu <= 1'b0;
		irq_wait(0, 1'b1, "irq pair");
		for (int i = 0; i < 4; i++)
			chk("copy", 32'(mdl.mem[8'h40 + i]), 32'(pat(8'(8'h10 + i))));
		dly <= 4'h0;
	endtask

	task automatic s_ring;
		td(1, 32'h20, 32'h60, 32'h0f04_0001);
		td(2, 32'h30, 32'h70, 32'h0f06_0000);
		td(3, 32'h38, 32'h80, 32'h0f02_0000);
		wr(12'h008, 32'h0001_6021);
		trig <= 24'h000020;
		repeat (4) @(posedge clk);
		trig <= '0;
		irq_wait(1, 1'b0, "trigger start");
		irq_wait(1, 1'b0, "next desc");
		irq_wait(1, 1'b0, "third desc");
		irq_wait(1, 1'b0, "ring back");
		wr(12'h00c, 32'h2);
		repeat (20) @(posedge clk);
		rd(12'h00c, 32'h1, 32'h0, "cancelled");
		chk("ring copy a", 32'(mdl.mem[8'h61]), 32'(pat(8'h21)));
		chk("ring copy b", 32'(mdl.mem[8'h70]), 32'(pat(8'h30)));
		chk("ring copy c", 32'(mdl.mem[8'h80]), 32'(pat(8'h38)));
	endtask

	task automatic s_stall;
		logic [31:0] q1, q2;
		td(4, 32'h90, 32'hff, 32'h0201_0000);
		wr(12'h010, 32'h81);
		wr(12'h014, 32'h1);
		repeat (60) @(posedge clk);
		wr(12'h010, 32'h1081);
		repeat (20) @(posedge clk);
		bus(1'b0, 12'h014, 32'h0, q1);
		repeat (40) @(posedge clk);
		bus(1'b0, 12'h014, 32'h0, q2);
		chk("stall holds", q2, q1);
		chk("stall flags", {30'h0, q1[1:0]}, 32'h3);
		wr(12'h010, 32'h81);
		repeat (40) @(posedge clk);
		bus(1'b0, 12'h014, 32'h0, q2);
		chk("resumed", 32'(q2[31:16] != q1[31:16]), 32'h1);
		wr(12'h014, 32'h2);
		repeat (20) @(posedge clk);
		rd(12'h014, 32'h1, 32'h0, "unbounded cancel");
	endtask

	task automatic s_nest;
		td(5, 32'h05, 32'hffff_f860, 32'h010c_0000);
		td(6, 32'h0, 32'ha0, 32'h0800_0000);
		td(10, 32'h11, 32'ha8, 32'h0800_0000);
		wr(12'h038, 32'h0038_0141);
		wr(12'h018, 32'h0000_00a1);
		wr(12'h01c, 32'h1);
		repeat (60) @(posedge clk);
		rd(12'h860, '1, 32'h0000_005f, "pool rewritten");
		chk("nested copy", 32'(mdl.mem[8'ha0]), 32'(pat(8'h5f)));
		chk("chain trigger", 32'(mdl.mem[8'ha8]), 32'(pat(8'h11)));
		rd(12'h03c, 32'h1, 32'h0, "chained done");
	endtask

	task automatic s_fair;
		logic [31:0] q1, q2;
		td(7, 32'h0, 32'hf0, 32'h0001_0000);
		td(8, 32'h0, 32'hf1, 32'h0001_0000);
		td(9, 32'h0, 32'hf2, 32'h0001_0000);
		wr(12'h020, 32'h0000_00e5);
		wr(12'h028, 32'h0000_0107);
		wr(12'h030, 32'h0000_0125);
		wr(12'h024, 32'h1);
		wr(12'h034, 32'h1);
		wr(12'h02c, 32'h1);
		repeat (80) @(posedge clk);
		bus(1'b0, 12'h02c, 32'h0, q1);
		chk("strict prio", q1, 32'h0000_0021);
		bus(1'b0, 12'h034, 32'h0, q2);
		chk("round robin", 32'(q2[31:16] != 16'h0), 32'h1);
		wr(12'h100, 32'h1);
		repeat (100) @(posedge clk);
		bus(1'b0, 12'h02c, 32'h0, q1);
		chk("fair share", 32'(q1[31:16] != 16'h0), 32'h1);
		wr(12'h024, 32'h2);
		wr(12'h02c, 32'h2);
		wr(12'h034, 32'h2);
		wr(12'h100, 32'h0);
	endtask

	task automatic conclude;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_regs;
		s_simple;
		s_ring;
		s_stall;
		s_nest;
		s_fair;
		conclude;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude;
	end
endmodule
